// ### src/slp_ctrl.sv
// Functional notes
// - Sleep only when armed at sleep instruction
// - Idle stops core and flash clocks
// - Idle wakes on every enabled interrupt
// - Noise mode also stops io clock
// - Noise mode wakes on listed sources only
// - Idle or noise entry starts conversion
// - Power-down stops oscillator and all domains
// - Power-down wakes on resets, level, pin, watchdog
// - Deep modes: ext line wakes only level-configured
// - Standby keeps oscillator, wakes in six cycles
// - Interrupt wake halts core four extra cycles
// - Sleep leaves register file and memory intact
// - Reset during sleep restarts at reset vector
// - Detector off in deep sleep when bit set
// - Detector off at entry, on at wake
// - Detector-off wake delay about 60 us
// - Detector-off bit changes only via unlock
// - Unlock window four, effect three, hold three
// - Stopped peripheral frozen, registers blocked
// - Clearing stop bit resumes peripheral unchanged
// - Peripheral stop acts in active and idle
// - Stop bits: timer16, timer8, serial, converter

`timescale 1ns/1ps

module slp_ctrl #(
  parameter int          BOD_WAKE_CYC = slp_pkg::BOD_WAKE_CYC,
  parameter logic [15:0] START_CYC    = 16'(slp_pkg::DEF_START_CYC)
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic [slp_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic [slp_pkg::DATA_W-1:0]    WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output      logic [slp_pkg::DATA_W-1:0]    RDATA,
  input  wire logic                          SLEEP_INSTR,
  input  wire logic                          CRYSTAL_SEL,
  input  wire logic                          CONV_ENABLED,
  input  wire slp_pkg::slp_wake_t            WAKE_SRC,
  output      logic [slp_pkg::NUM_DOM-1:0]   DOM_CLK,
  output      logic [slp_pkg::NUM_PERIPH-1:0] PERIPH_CLK,
  output      logic [slp_pkg::NUM_PERIPH-1:0] PERIPH_REG_BLOCK,
  output      logic                          OSC_EN,
  output      logic                          CORE_HALT,
  output      logic                          CONV_START,
  output      logic                          DETECTOR_EN,
  output      logic                          COMP_OFF,
  output      logic                          RESUME_IRQ,
  output      logic                          RESUME_RESET
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  slp_pkg::slp_regs_t                   r_ff;
  slp_pkg::slp_regs_t                   nxt_r;
  logic [slp_pkg::NUM_DOM-1:0]          dom_en;
  logic [slp_pkg::NUM_PERIPH-1:0]       per_en;
  logic                                 deep_mode;
  logic                                 brownout_sleep_off_active;
  logic                                 wake_irq;
  logic                                 ext_ok;
  logic [15:0]                          wake_base;
  slp_pkg::slp_mode_t                   entry_mode;
  logic                                 wr_mcr;
  logic                                 wr_brownout_sleep_off;
  logic                                 wr_unlk;

  // ------------------------------------------------------------------
  // Helper decode
  // ------------------------------------------------------------------

  // Power-down and standby are the modes where the detector may drop.
  assign deep_mode   = (r_ff.mode == slp_pkg::MODE_PDOWN) ||
                       (r_ff.mode == slp_pkg::MODE_STBY);
  assign brownout_sleep_off_active = (r_ff.brownout_sleep_off_hold != 3'h0);

  // Outside idle, an edge-configured external line must not wake us.
  assign ext_ok = WAKE_SRC.ext_irq &&
                  ((r_ff.mode == slp_pkg::MODE_IDLE) || WAKE_SRC.ext_level);

  // Per-mode wake mask for interrupt sources; resets are handled apart.
  always_comb begin
    wake_irq = 1'b0;
    unique case (r_ff.mode)
      slp_pkg::MODE_IDLE: begin
        wake_irq = ext_ok || WAKE_SRC.pin_chg || WAKE_SRC.nvm_rdy ||
                   WAKE_SRC.conv_done || WAKE_SRC.other_io ||
                   WAKE_SRC.wdt_irq;
      end
      slp_pkg::MODE_NOISE: begin
        wake_irq = ext_ok || WAKE_SRC.pin_chg || WAKE_SRC.nvm_rdy ||
                   WAKE_SRC.conv_done || WAKE_SRC.wdt_irq;
      end
      slp_pkg::MODE_PDOWN, slp_pkg::MODE_STBY: begin
        wake_irq = ext_ok || WAKE_SRC.pin_chg || WAKE_SRC.wdt_irq;
      end
    endcase
  end

  // A level source is only seen while it is held; a short pulse that
  // ends before this sample is lost, which the source must avoid.

  // Start-up length: the detector restart dominates, then standby's
  // short restart, otherwise the oscillator start-up time.
  always_comb begin
    if (r_ff.brownout_sleep_off_latched) begin
      wake_base = 16'(BOD_WAKE_CYC);
    end else if (r_ff.mode == slp_pkg::MODE_STBY) begin
      wake_base = slp_pkg::STBY_WAKE_CYC;
    end else begin
      wake_base = START_CYC;
    end
  end

  // Standby needs a crystal; without one the oscillator cannot be
  // trusted to idle usefully, so the request degrades to power-down.
  always_comb begin
    entry_mode = slp_pkg::slp_mode_t'(r_ff.sel);
    if ((r_ff.sel == slp_pkg::MODE_STBY) && !CRYSTAL_SEL) begin
      entry_mode = slp_pkg::MODE_PDOWN;
    end
  end

  assign wr_mcr  = WR && (ADDR == slp_pkg::MCR_ADDR);
  assign wr_brownout_sleep_off = WDATA[slp_pkg::MCR_BROWNOUT_SLEEP_OFF];
  assign wr_unlk = WDATA[slp_pkg::MCR_UNLK];

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    nxt_r              = r_ff;
    nxt_r.conv_start   = 1'b0;
    nxt_r.resume_irq   = 1'b0;
    nxt_r.resume_reset = 1'b0;
    nxt_r.rdata        = '0;

    // Timed unlock counters run down on every cycle.
    if (r_ff.unlock_cnt != 3'h0) begin
      nxt_r.unlock_cnt = r_ff.unlock_cnt - 3'h1;
    end
    if (r_ff.brownout_sleep_off_hold != 3'h0) begin
      nxt_r.brownout_sleep_off_hold = r_ff.brownout_sleep_off_hold - 3'h1;
    end
    if (r_ff.brownout_sleep_off_dly != 3'h0) begin
      nxt_r.brownout_sleep_off_dly = r_ff.brownout_sleep_off_dly - 3'h1;
      if (r_ff.brownout_sleep_off_dly == 3'h1) begin
        nxt_r.brownout_sleep_off_hold = slp_pkg::BROWNOUT_SLEEP_OFF_HOLD;
      end
    end

    // Register writes. Arm and mode select are plain bits; the
    // detector-off bit only moves through the two-step sequence.
    if (wr_mcr) begin
      nxt_r.arm = WDATA[slp_pkg::MCR_ARM];
      nxt_r.sel = WDATA[slp_pkg::MCR_SEL_LO +: 2];
      if (wr_brownout_sleep_off && wr_unlk) begin
        nxt_r.unlock_cnt = slp_pkg::UNLOCK_WIN;
      end else if (wr_brownout_sleep_off && (r_ff.unlock_cnt != 3'h0)) begin
        nxt_r.unlock_cnt = 3'h0;
        nxt_r.brownout_sleep_off_dly   = slp_pkg::BROWNOUT_SLEEP_OFF_DLY;
      end
    end
    if (WR && (ADDR == slp_pkg::PCS_ADDR)) begin
      nxt_r.pcs = WDATA[slp_pkg::NUM_PERIPH-1:0];
    end
    if (WR && (ADDR == slp_pkg::CMP_ADDR)) begin
      nxt_r.cmp_off = WDATA[slp_pkg::CMP_OFF];
    end

    // Register reads: answer lands in the cycle after the strobe.
    if (RD) begin
      unique case (ADDR)
        slp_pkg::MCR_ADDR: begin
          nxt_r.rdata[slp_pkg::MCR_BROWNOUT_SLEEP_OFF]        = brownout_sleep_off_active;
          nxt_r.rdata[slp_pkg::MCR_ARM]         = r_ff.arm;
          nxt_r.rdata[slp_pkg::MCR_SEL_LO +: 2] = r_ff.sel;
          nxt_r.rdata[slp_pkg::MCR_UNLK]        = (r_ff.unlock_cnt != 3'h0);
        end
        slp_pkg::PCS_ADDR: begin
          nxt_r.rdata[slp_pkg::NUM_PERIPH-1:0] = r_ff.pcs;
        end
        slp_pkg::CMP_ADDR: begin
          nxt_r.rdata[slp_pkg::CMP_OFF] = r_ff.cmp_off;
        end
        slp_pkg::STAT_ADDR: begin
          nxt_r.rdata = {r_ff.state, r_ff.mode, r_ff.brownout_sleep_off_latched,
                         DETECTOR_EN, 2'h0};
        end
        default: begin
          nxt_r.rdata = '0;
        end
      endcase
    end

    // Sleep sequencing. Nothing here touches core storage: the core is
    // only stopped, so its register file and memory keep their contents.
    unique case (r_ff.state)
      slp_pkg::ST_ACTIVE: begin
        if (SLEEP_INSTR && r_ff.arm) begin
          nxt_r.state        = slp_pkg::ST_SLEEP;
          nxt_r.mode         = entry_mode;
          nxt_r.brownout_sleep_off_latched = brownout_sleep_off_active &&
                               ((entry_mode == slp_pkg::MODE_PDOWN) ||
                                (entry_mode == slp_pkg::MODE_STBY));
          nxt_r.conv_start   = CONV_ENABLED &&
                               ((entry_mode == slp_pkg::MODE_IDLE) ||
                                (entry_mode == slp_pkg::MODE_NOISE));
        end
      end
      slp_pkg::ST_SLEEP: begin
        if (WAKE_SRC.reset_req) begin
          nxt_r.state        = slp_pkg::ST_WAKE;
          nxt_r.by_reset     = 1'b1;
          nxt_r.wake_cnt     = wake_base;
          nxt_r.brownout_sleep_off_latched = 1'b0;
        end else if (wake_irq) begin
          nxt_r.state        = slp_pkg::ST_WAKE;
          nxt_r.by_reset     = 1'b0;
          nxt_r.wake_cnt     = wake_base + slp_pkg::IRQ_HALT_CYC;
          nxt_r.brownout_sleep_off_latched = 1'b0;
        end
      end
      slp_pkg::ST_WAKE: begin
        // A reset arriving during start-up still forces the vector.
        if (WAKE_SRC.reset_req) begin
          nxt_r.by_reset = 1'b1;
        end
        if (r_ff.wake_cnt <= 16'h0001) begin
          nxt_r.state        = slp_pkg::ST_ACTIVE;
          nxt_r.wake_cnt     = 16'h0000;
          nxt_r.resume_reset = r_ff.by_reset || WAKE_SRC.reset_req;
          nxt_r.resume_irq   = !(r_ff.by_reset || WAKE_SRC.reset_req);
        end else begin
          nxt_r.wake_cnt = r_ff.wake_cnt - 16'h0001;
        end
      end
      default: begin
        nxt_r.state = slp_pkg::ST_ACTIVE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_ff <= slp_pkg::SLP_REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ------------------------------------------------------------------
  // Clock domain enables
  // ------------------------------------------------------------------

  // Core and flash run only when active, so the core stays stopped for
  // the whole start-up count. Io and converter clocks restart at wake
  // so the peripherals are live before the core resumes.
  always_comb begin
    dom_en = '1;
    if (r_ff.state != slp_pkg::ST_ACTIVE) begin
      dom_en[slp_pkg::DOM_CORE]  = 1'b0;
      dom_en[slp_pkg::DOM_FLASH] = 1'b0;
    end
    if (r_ff.state == slp_pkg::ST_SLEEP) begin
      dom_en[slp_pkg::DOM_IO]   = (r_ff.mode == slp_pkg::MODE_IDLE);
      dom_en[slp_pkg::DOM_CONV] = (r_ff.mode == slp_pkg::MODE_IDLE) ||
                                  (r_ff.mode == slp_pkg::MODE_NOISE);
    end
  end

  // Oscillator stops only in power-down; standby keeps it for a fast
  // restart at the cost of its running current.
  assign OSC_EN = !((r_ff.state == slp_pkg::ST_SLEEP) &&
                    (r_ff.mode == slp_pkg::MODE_PDOWN));

  // Detector drops as soon as the sleep state is entered and returns
  // on the first wake cycle.
  assign DETECTOR_EN = !((r_ff.state == slp_pkg::ST_SLEEP) &&
                         r_ff.brownout_sleep_off_latched && deep_mode);

  // ------------------------------------------------------------------
  // Domain and peripheral clock gates
  // ------------------------------------------------------------------

  // Each peripheral clock hangs off its parent domain, so in the deeper
  // modes it is stopped anyway and its stop bit has no extra effect.
  // Freezing the clock rather than resetting keeps peripheral state, so
  // a cleared stop bit resumes exactly where it left off.
  always_comb begin
    per_en = '0;
    for (int i = 0; i < slp_pkg::NUM_PERIPH; i++) begin
      if (i == slp_pkg::PCS_CONV) begin
        per_en[i] = !r_ff.pcs[i] && dom_en[slp_pkg::DOM_CONV];
      end else begin
        per_en[i] = !r_ff.pcs[i] && dom_en[slp_pkg::DOM_IO];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < slp_pkg::NUM_DOM; g++) begin : g_dom
      slp_clk_gate u_gate (
        .clk   (CLK),
        .rst_n (RST_N),
        .en    (dom_en[g]),
        .gclk  (DOM_CLK[g])
      );
    end
    for (g = 0; g < slp_pkg::NUM_PERIPH; g++) begin : g_per
      slp_clk_gate u_gate (
        .clk   (CLK),
        .rst_n (RST_N),
        .en    (per_en[g]),
        .gclk  (PERIPH_CLK[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------

  // Register access to a stopped peripheral is blocked by its bus glue.
  // Software should disable the peripheral first; nothing here checks.
  assign PERIPH_REG_BLOCK = r_ff.pcs;
  assign COMP_OFF         = r_ff.cmp_off;
  assign CORE_HALT        = (r_ff.state != slp_pkg::ST_ACTIVE);
  assign CONV_START       = r_ff.conv_start;
  assign RESUME_IRQ       = r_ff.resume_irq;
  assign RESUME_RESET     = r_ff.resume_reset;
  assign RDATA            = r_ff.rdata;

endmodule : slp_ctrl

// ### common/slp_pkg.sv
package slp_pkg;

  // ----------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 8;
  localparam logic [3:0]  MCR_ADDR    = 4'h0;   // mcu_control_reg
  localparam logic [3:0]  PCS_ADDR    = 4'h1;   // peripheral_clock_stop_reg
  localparam logic [3:0]  CMP_ADDR    = 4'h2;   // comparator_ctrl_status_reg
  localparam logic [3:0]  STAT_ADDR   = 4'h3;   // controller status, read only
  localparam int          MCR_BROWNOUT_SLEEP_OFF    = 7;      // brownout_sleep_off
  localparam int          MCR_ARM     = 5;      // sleep_arm
  localparam int          MCR_SEL_LO  = 3;      // sleep_select[1:0] at 4:3
  localparam int          MCR_UNLK    = 2;      // brownout_sleep_unlock
  localparam int          CMP_OFF     = 7;      // comparator_off
  localparam int          NUM_PERIPH  = 4;
  localparam int          PCS_CONV    = 0;      // converter stop bit
  localparam int          PCS_SER     = 1;      // universal serial interface
  localparam int          PCS_T8      = 2;      // 8-bit timer
  localparam int          PCS_T16     = 3;      // 16-bit timer
  localparam int          NUM_DOM     = 4;
  localparam int          DOM_CORE    = 0;
  localparam int          DOM_FLASH   = 1;
  localparam int          DOM_IO      = 2;
  localparam int          DOM_CONV    = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          BOD_WAKE_NS   = 60000;
  localparam int          BOD_WAKE_CYC  = BOD_WAKE_NS / CLK_PERIOD_NS;
  localparam int          DEF_START_CYC = 16;
  localparam logic [2:0]  UNLOCK_WIN    = 3'h4;
  localparam logic [2:0]  BROWNOUT_SLEEP_OFF_DLY      = 3'h3;
  localparam logic [2:0]  BROWNOUT_SLEEP_OFF_HOLD     = 3'h3;
  localparam logic [15:0] STBY_WAKE_CYC = 16'h0006;
  localparam logic [15:0] IRQ_HALT_CYC  = 16'h0004;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE  = 2'h0,
    MODE_NOISE = 2'h1,
    MODE_PDOWN = 2'h2,
    MODE_STBY  = 2'h3
  } slp_mode_t;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} slp_state_t;

  typedef struct packed {
    logic reset_req;   // external, watchdog or brown-out reset request
    logic ext_irq;     // ext_irq_line interrupt pending and enabled
    logic ext_level;   // ext_irq_line configured as level interrupt
    logic pin_chg;
    logic nvm_rdy;
    logic conv_done;
    logic other_io;
    logic wdt_irq;
  } slp_wake_t;

  typedef struct packed {
    slp_state_t  state;
    slp_mode_t   mode;
    logic        arm;
    logic [1:0]  sel;
    logic [2:0]  unlock_cnt;
    logic [2:0]  brownout_sleep_off_dly;
    logic [2:0]  brownout_sleep_off_hold;
    logic        brownout_sleep_off_latched;
    logic        by_reset;
    logic [15:0] wake_cnt;
    logic [3:0]  pcs;
    logic        cmp_off;
    logic        conv_start;
    logic        resume_irq;
    logic        resume_reset;
    logic [7:0]  rdata;
  } slp_regs_t;

  localparam slp_regs_t SLP_REGS_RST = '0;

endpackage : slp_pkg

// ### src/slp_clk_gate.sv
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Glitch-free clock gate
// --------------------------------------------------------------------
module slp_clk_gate (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  output      logic gclk
);

  logic en_ff;

  // The enable changes only while the clock is low, so the AND never
  // sees a change during a high phase and cannot cut a pulse short.
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= 1'b0;
    end else begin
      en_ff <= en;
    end
  end

  // Gated clock; stays low while disabled so the domain freezes.
  assign gclk = clk & en_ff;

endmodule : slp_clk_gate

// ### test/slp_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Core and wake-source model
// ----------------------------------------------------------------
module slp_core_model (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               cmd_sleep,
  input  wire slp_pkg::slp_wake_t cmd_wake,
  input  wire logic               RESUME_IRQ,
  input  wire logic               RESUME_RESET,
  output      slp_pkg::slp_wake_t WAKE_SRC,
  output      logic               SLEEP_INSTR
);
  // A source keeps its level until the resume, because a short level could be lost while waking.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SLEEP_INSTR <= 1'b0;
      WAKE_SRC    <= '0;
    end else begin
      SLEEP_INSTR <= cmd_sleep;
      if (RESUME_IRQ || RESUME_RESET) WAKE_SRC <= '0;
      else if (cmd_wake != '0) WAKE_SRC <= cmd_wake;
    end
  end
endmodule : slp_core_model

// ### test/slp_ctrl_sva.sv
`timescale 1ns/1ps

module slp_ctrl_sva (
  input wire logic                           CLK,
  input wire logic                           RST_N,
  input wire logic [slp_pkg::ADDR_W-1:0]     ADDR,
  input wire logic [slp_pkg::DATA_W-1:0]     WDATA,
  input wire logic                           WR,
  input wire logic                           SLEEP_INSTR,
  input wire logic [slp_pkg::NUM_PERIPH-1:0] PERIPH_REG_BLOCK,
  input wire logic                           OSC_EN,
  input wire logic                           CORE_HALT,
  input wire logic                           CONV_START,
  input wire logic                           DETECTOR_EN,
  input wire logic                           COMP_OFF,
  input wire logic                           RESUME_IRQ,
  input wire logic                           RESUME_RESET
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_sleep_armed: assert property ($rose(CORE_HALT) |-> $past(SLEEP_INSTR))
    else $error("halt without sleep instruction");
  a_conv_pulse: assert property (CONV_START |-> $rose(CORE_HALT) ##1 !CONV_START)
    else $error("conversion start not at sleep entry");
  a_osc_asleep: assert property (!OSC_EN |-> CORE_HALT)
    else $error("oscillator off while running");
  a_detector_asleep: assert property (!DETECTOR_EN |-> CORE_HALT && !CONV_START)
    else $error("detector off outside a deep sleep");
  a_detector_back: assert property ($fell(CORE_HALT) |-> DETECTOR_EN && OSC_EN)
    else $error("detector or oscillator not back on wake");
  a_resume_kind: assert property ($fell(CORE_HALT) |-> RESUME_IRQ != RESUME_RESET)
    else $error("wake without exactly one resume kind");
  a_resume_once: assert property ((RESUME_IRQ || RESUME_RESET) |->
    !CORE_HALT ##1 !(RESUME_IRQ || RESUME_RESET))
    else $error("resume pulse wrong");
  a_halt_extra: assert property (RESUME_IRQ |-> $past(CORE_HALT, 5))
    else $error("interrupt wake too short");
  a_block_write: assert property (WR && ADDR == slp_pkg::PCS_ADDR |=>
    PERIPH_REG_BLOCK == 4'($past(WDATA)))
    else $error("stop bits not taken");
  a_block_hold: assert property (!(WR && ADDR == slp_pkg::PCS_ADDR) |=> $stable(PERIPH_REG_BLOCK))
    else $error("stop bits changed without write");
  a_comp_write: assert property (WR && ADDR == slp_pkg::CMP_ADDR |=> COMP_OFF == |(8'h80 & $past(WDATA)))
    else $error("comparator off bit not taken");
endmodule : slp_ctrl_sva

bind slp_ctrl slp_ctrl_sva u_sva (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .SLEEP_INSTR(SLEEP_INSTR), .PERIPH_REG_BLOCK(PERIPH_REG_BLOCK), .OSC_EN(OSC_EN), .CORE_HALT(CORE_HALT),
  .CONV_START(CONV_START), .DETECTOR_EN(DETECTOR_EN), .COMP_OFF(COMP_OFF), .RESUME_IRQ(RESUME_IRQ),
  .RESUME_RESET(RESUME_RESET));

// ### test/slp_ctrl_bench.sv
`timescale 1ns/1ps

module slp_ctrl_bench;
  localparam int S = 16;
  localparam int B = 20;
  typedef struct packed {logic [1:0] sel; logic xtal; logic conv; logic [7:0] src;
    logic [3:0] dom; logic osc; logic wake;} slp_row_t;
  logic clk, rst_n, wr_s, rd_s, crystal_sel, conv_enabled, cmd_sleep, sleep_instr;
  logic [3:0] addr, dom_clk, periph_clk, periph_reg_block;
  logic [7:0] wdata, rdata;
  logic osc_en, core_halt, conv_start, detector_en, comp_off, resume_irq, resume_reset;
  slp_pkg::slp_wake_t cmd_wake, wake_src;
  int mismatches, n_tests, base;
  slp_row_t r;
  // Each row: mode, crystal, converter on, source, domains running, oscillator, wakes.
  slp_row_t rows [12] = '{
    '{2'h0, 1'h0, 1'h1, 8'h02, 4'hC, 1'h1, 1'h1}, '{2'h0, 1'h0, 1'h0, 8'h40, 4'hC, 1'h1, 1'h1},
    '{2'h1, 1'h0, 1'h1, 8'h02, 4'h8, 1'h1, 1'h0}, '{2'h1, 1'h0, 1'h0, 8'h04, 4'h8, 1'h1, 1'h1},
    '{2'h1, 1'h0, 1'h1, 8'h08, 4'h8, 1'h1, 1'h1}, '{2'h2, 1'h0, 1'h1, 8'h40, 4'h0, 1'h0, 1'h0},
    '{2'h2, 1'h0, 1'h0, 8'h60, 4'h0, 1'h0, 1'h1}, '{2'h2, 1'h0, 1'h0, 8'h08, 4'h0, 1'h0, 1'h0},
    '{2'h2, 1'h0, 1'h0, 8'h01, 4'h0, 1'h0, 1'h1}, '{2'h3, 1'h1, 1'h0, 8'h01, 4'h0, 1'h1, 1'h1},
    '{2'h3, 1'h0, 1'h0, 8'h10, 4'h0, 1'h0, 1'h1}, '{2'h3, 1'h1, 1'h0, 8'h80, 4'h0, 1'h1, 1'h1}};

  slp_ctrl #(.BOD_WAKE_CYC(B), .START_CYC(16'(S))) u_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .SLEEP_INSTR(sleep_instr), .CRYSTAL_SEL(crystal_sel),
    .CONV_ENABLED(conv_enabled), .WAKE_SRC(wake_src), .DOM_CLK(dom_clk), .PERIPH_CLK(periph_clk),
    .PERIPH_REG_BLOCK(periph_reg_block), .OSC_EN(osc_en), .CORE_HALT(core_halt), .CONV_START(conv_start),
    .DETECTOR_EN(detector_en), .COMP_OFF(comp_off), .RESUME_IRQ(resume_irq), .RESUME_RESET(resume_reset));
  slp_core_model u_core (.CLK(clk), .RST_N(rst_n), .cmd_sleep(cmd_sleep), .cmd_wake(cmd_wake),
    .RESUME_IRQ(resume_irq), .RESUME_RESET(resume_reset), .WAKE_SRC(wake_src), .SLEEP_INSTR(sleep_instr));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %b", $time, m, got);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk_val
  // The strobe drops at the edge that takes it, so a following call leaves one idle cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk_val(rdata, e, "read");
  endtask : rd_chk
  // Domain clocks are sampled in the high phase, where each one shows its gate enable.
  task automatic go_sleep(input logic h, input logic [3:0] dom, input logic osc, input logic cs);
    @(posedge clk);
    cmd_sleep <= 1'b1;
    @(posedge clk);
    cmd_sleep <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(core_halt, h, "halt");
    chk_bit(conv_start, cs, "conversion start");
    @(posedge clk);
    #1;
    chk_val(8'(dom_clk), 8'(dom), "domains");
    chk_bit(osc_en, osc, "oscillator");
  endtask : go_sleep
  task automatic wake(input logic [7:0] src, input int n_exp, input logic irq);
    int n;
    @(posedge clk);
    cmd_wake <= slp_pkg::slp_wake_t'(src);
    n = 0;
    while (n < 300 && core_halt !== 1'b0) begin
      @(posedge clk);
      cmd_wake <= '0;
      #1;
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      $display("[ERR] %0t wake timed out", $time);
      end_sim();
    end else begin
      chk_val(8'(n), 8'(n_exp + 2), "wake cycles");
      chk_bit(resume_irq, irq, "handler resume");
      chk_bit(resume_reset, !irq, "reset resume");
      chk_bit(detector_en, 1'b1, "detector back");
    end
  endtask : wake
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_n, wr_s, rd_s, crystal_sel, conv_enabled, cmd_sleep, addr, wdata} = '0;
    cmd_wake = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(osc_en & detector_en & !core_halt, 1'b1, "outputs in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(slp_pkg::MCR_ADDR, 8'h00);
    rd_chk(slp_pkg::STAT_ADDR, 8'h04);
    rd_chk(4'hF, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      crystal_sel <= r.xtal;
      conv_enabled <= r.conv;
      wr(slp_pkg::MCR_ADDR, 8'hA0 | {3'h0, r.sel, 3'h0});
      go_sleep(1'b1, r.dom, r.osc, r.conv && !r.sel[1]);
      chk_bit(detector_en, 1'b1, "detector kept");
      base = (r.sel == 2'h3 && r.xtal) ? 6 : S;
      if (r.wake) wake(r.src, base + (r.src[7] ? 0 : 4), !r.src[7]);
      else begin
        @(posedge clk);
        cmd_wake <= slp_pkg::slp_wake_t'(r.src);
        @(posedge clk);
        cmd_wake <= '0;
        repeat (8) @(posedge clk);
        #1;
        chk_bit(core_halt, 1'b1, "ignored source");
        wake(8'h80, base, 1'b0);
      end
      $display("test row %0d done", i);
    end
    // Unarmed sleep instruction must be ignored.
    wr(slp_pkg::MCR_ADDR, 8'h08);
    go_sleep(1'b0, 4'hF, 1'b1, 1'b0);
    // Converter stays disabled; the write stops only the timer16 and serial clocks, not its own.
    conv_enabled <= 1'b0;
    wr(slp_pkg::PCS_ADDR, 8'hFA);
    rd_chk(slp_pkg::PCS_ADDR, 8'h0A);
    chk_val(8'(periph_reg_block), 8'h0A, "blocked");
    @(posedge clk);
    #1;
    chk_val(8'(periph_clk), 8'h05, "peripheral clocks");
    wr(slp_pkg::PCS_ADDR, 8'h00);
    @(posedge clk);
    #1;
    chk_val(8'(periph_clk), 8'h0F, "peripheral restart");
    wr(slp_pkg::CMP_ADDR, 8'h80);
    rd_chk(slp_pkg::CMP_ADDR, 8'h80);
    chk_bit(comp_off, 1'b1, "comparator off");
    $display("test peripherals done");
    // Unlock pair, then power-down taken inside the three-cycle hold.
    // The read lands before the hold starts, so the bit must still read zero.
    wr(slp_pkg::MCR_ADDR, 8'hB4);
    wr(slp_pkg::MCR_ADDR, 8'hB0);
    rd_chk(slp_pkg::MCR_ADDR, 8'h30);
    go_sleep(1'b1, 4'h0, 1'b0, 1'b0);
    chk_bit(detector_en, 1'b0, "detector off");
    wake(8'h10, B + 4, 1'b1);
    // Settings survive the sleep; the detector-off bit has cleared itself.
    rd_chk(slp_pkg::MCR_ADDR, 8'h30);
    $display("test detector done");
    end_sim();
  end
endmodule : slp_ctrl_bench
